// >>> core/apr_pkg.sv
// Shared constants for the audio port routing and clock monitor block.
// Assumes a 200 MHz system clock and an 8-bit register port.
package apr_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_ROUTE = 8'h35;
  localparam logic [7:0] ADDR_RATE  = 8'h37;
  localparam logic [7:0] ADDR_RATIO = 8'h38;
  localparam logic [7:0] ADDR_FLAGS = 8'h39;
  localparam logic [7:0] ROUTE_RST  = 8'h11;
  localparam logic [7:0] MON_RST    = 8'h00;
  localparam int LSRC_LSB     = 4;
  localparam int RSRC_LSB     = 0;
  localparam int RATIO_HI_LSB = 4;
  localparam int RESV_LSB     = 6;
  // Output source selector codes
  typedef enum logic [1:0] {
    SRC_MUTE  = 2'h0,
    SRC_OWN   = 2'h1,
    SRC_OTHER = 2'h2,
    SRC_RSVD  = 2'h3
  } apr_src_type;
  // Detected sample rate codes
  localparam logic [3:0] RATE_ERR = 4'h0;
  localparam logic [3:0] RATE_16K = 4'h4;
  localparam logic [3:0] RATE_32K = 4'h6;
  localparam logic [3:0] RATE_48K = 4'h9;
  localparam logic [3:0] RATE_96K = 4'hB;
  localparam logic [3:0] RATE_192K = 4'hD;
  // Flag bit positions
  localparam int FLG_RATE     = 0;
  localparam int FLG_SCLK_OK  = 1;
  localparam int FLG_MISSING  = 2;
  localparam int FLG_PLL_LOCK = 3;
  localparam int FLG_PLL_OVR  = 4;
  localparam int FLG_SCLK_OVR = 5;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS        = 5;
  localparam int FRAME16_NS    = 62500;
  localparam int FRAME32_NS    = 31250;
  localparam int FRAME48_NS    = 20833;
  localparam int FRAME96_NS    = 10417;
  localparam int FRAME192_NS   = 5208;
  localparam int SCLK_MISS_NS  = 2000;
  localparam int SCLK_MISS_CYC = SCLK_MISS_NS / CLK_NS;
  localparam int SCLK_MIN_NS   = 30;
  localparam int SCLK_MIN_CYC  = (SCLK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RATIO_MIN     = 32;
  localparam int RATIO_MAX     = 512;
  localparam int TOL_SHIFT     = 5;
endpackage

// >>> core/apr_smp_if.sv
// Carries one received stereo sample pair between receiver and router.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface apr_smp_if #(parameter int SAMPLE_W = 24);
  logic [SAMPLE_W-1:0] left;
  logic [SAMPLE_W-1:0] right;
  logic                strobe;
  modport tx (output left, output right, output strobe);
  modport rx (input left, input right, input strobe);
endinterface
`default_nettype wire

// >>> core/apr_serial_rx.sv
// Serial audio deserialiser: shifts data on bit clock rising edges.
// Assumes synchronised frame clock and data, and a one-cycle edge pulse.
`timescale 1ns/1ps
`default_nettype none
module apr_serial_rx #(
  parameter int SAMPLE_W = 24
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sclk_rise,
  input  wire logic lrclk_s,
  input  wire logic sdin_s,
  apr_smp_if.tx     smp
);
  logic [SAMPLE_W-1:0] shift_r;
  logic                lr_last_r;

  // Shift in MSB first; the last SAMPLE_W bits before a slot change win
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_r   <= '0;
      lr_last_r <= 1'b0;
    end else if (sclk_rise) begin
      shift_r   <= {shift_r[SAMPLE_W-2:0], sdin_s};
      lr_last_r <= lrclk_s;
    end
  end

  // Latch a slot at each frame clock change; pair completes after right slot
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      smp.left   <= '0;
      smp.right  <= '0;
      smp.strobe <= 1'b0;
    end else begin
      smp.strobe <= 1'b0;
      if (sclk_rise && (lrclk_s != lr_last_r)) begin
        if (!lr_last_r) begin
          smp.left <= shift_r;
        end else begin
          smp.right  <= shift_r;
          smp.strobe <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/apr_route_mon.sv
// Output channel routing and serial clock monitor with its registers.
// Assumes the register port and config inputs come from clk logic, and
// the serial pins and PLL status come from outside and are synchronised.
//
// Notes on behaviour
// - Left source: 00 zero, 01 incoming left, 10 incoming right; reset 01.
// - Right source: 00 zero, 01 incoming right, 10 incoming left; reset 01.
// - Read-only rate code: 0 error, 4/6/9/B/D for 16/32/48/96/192 kHz.
// - Rate monitor bits 5-4 hold the two top bits of the ratio.
// - Separate register holds low eight ratio bits; zero after reset.
// - Bit clock valid only when ratio is stable and within 32 to 512.
// - Auto rate mode: flag bit 0 reports whether detected rate is bad.
// - Ignore-rate-error setting never masks the rate error flag.
// - Flag bit 2 set when the bit clock is missing.
// - Flag bit 3 shows PLL lock; a disabled PLL reads unlocked.
// - Flag bit 4 set when the PLL runs over rate.
// - Flag bit 5 set when the bit clock runs over rate.
`timescale 1ns/1ps
`default_nettype none
module apr_route_mon
#(
  parameter int SAMPLE_W  = 24,
  parameter int F16_CYC   = apr_pkg::FRAME16_NS / apr_pkg::CLK_NS,
  parameter int F32_CYC   = apr_pkg::FRAME32_NS / apr_pkg::CLK_NS,
  parameter int F48_CYC   = apr_pkg::FRAME48_NS / apr_pkg::CLK_NS,
  parameter int F96_CYC   = apr_pkg::FRAME96_NS / apr_pkg::CLK_NS,
  parameter int F192_CYC  = apr_pkg::FRAME192_NS / apr_pkg::CLK_NS
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                sclk,
  input  wire logic                lrclk,
  input  wire logic                sdin,
  input  wire logic                pll_enable,
  input  wire logic                pll_locked,
  input  wire logic                pll_overrate,
  input  wire logic [2:0]          rate_mode,
  input  wire logic [3:0]          cfg_rate_code,
  input  wire logic                rate_error_ignore,
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr_en,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_rd_en,
  output logic [7:0]               reg_rdata_r,
  output logic [SAMPLE_W-1:0]      left_out_r,
  output logic [SAMPLE_W-1:0]      right_out_r,
  output logic                     out_valid_r
);
  import apr_pkg::*;

  // ****************************************
  // Parameter checks
  // ****************************************
  if (SAMPLE_W < 8 || SAMPLE_W > 32) begin : g_bad_w
    $error("SAMPLE_W must lie between 8 and 32");
  end
  if (F16_CYC >= 65535 || F192_CYC < 64) begin : g_bad_f
    $error("Frame cycle counts out of counter range");
  end
  localparam int NSYNC = 6;
  localparam int IX_SCLK = 0;
  localparam int IX_LR   = 1;
  localparam int IX_DIN  = 2;
  localparam int IX_PEN  = 3;
  localparam int IX_PLK  = 4;
  localparam int IX_POV  = 5;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync_q1;
  logic [NSYNC-1:0] sync_q2;
  logic             sclk_q3_r;
  logic             lr_q3_r;
  assign async_in = {pll_overrate, pll_locked, pll_enable, sdin, lrclk, sclk};

  // Two flops per pin; only the second stage feeds any logic
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        sync_q1[i] <= 1'b0;
        sync_q2[i] <= 1'b0;
      end else begin
        sync_q1[i] <= async_in[i];
        sync_q2[i] <= sync_q1[i];
      end
    end
  end

  // Third stage for edge finding
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_q3_r <= 1'b0;
      lr_q3_r   <= 1'b0;
    end else begin
      sclk_q3_r <= sync_q2[IX_SCLK];
      lr_q3_r   <= sync_q2[IX_LR];
    end
  end

  logic sclk_rise;
  logic frame_start;
  assign sclk_rise   = sync_q2[IX_SCLK] & ~sclk_q3_r;
  // Frame begins with the left slot, i.e. the frame clock falling
  assign frame_start = ~sync_q2[IX_LR] & lr_q3_r;

  // ****************************************
  // Receiver
  // ****************************************
  apr_smp_if #(.SAMPLE_W(SAMPLE_W)) smp ();
  apr_serial_rx #(.SAMPLE_W(SAMPLE_W)) u_rx (
    .clk       (clk),
    .rst_n     (rst_n),
    .sclk_rise (sclk_rise),
    .lrclk_s   (sync_q2[IX_LR]),
    .sdin_s    (sync_q2[IX_DIN]),
    .smp       (smp.tx)
  );

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  route_r;
  logic [1:0]  rate_resv_r;
  logic [1:0]  flag_resv_r;
  logic [9:0]  ratio_r;
  logic [3:0]  rate_code_r;
  logic [5:0]  flags_r;
  apr_src_type lsrc;
  apr_src_type rsrc;
  assign lsrc = apr_src_type'(route_r[LSRC_LSB +: 2]);
  assign rsrc = apr_src_type'(route_r[RSRC_LSB +: 2]);

  // Writes land only on writable bits; monitor fields keep their value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      route_r     <= ROUTE_RST;
      rate_resv_r <= 2'h0;
      flag_resv_r <= 2'h0;
    end else if (reg_wr_en) begin
      unique case (reg_addr)
        ADDR_ROUTE: route_r <= reg_wdata;
        ADDR_RATE:  rate_resv_r <= reg_wdata[RESV_LSB +: 2];
        ADDR_FLAGS: flag_resv_r <= reg_wdata[RESV_LSB +: 2];
        default: ;
      endcase
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_r <= MON_RST;
    end else if (reg_rd_en) begin
      unique case (reg_addr)
        ADDR_ROUTE: reg_rdata_r <= route_r;
        ADDR_RATE:  reg_rdata_r <= {rate_resv_r, ratio_r[9:8], rate_code_r};
        ADDR_RATIO: reg_rdata_r <= ratio_r[7:0];
        ADDR_FLAGS: reg_rdata_r <= {flag_resv_r, flags_r};
        default:    reg_rdata_r <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Frame measurement
  // ****************************************
  logic [9:0]  bclk_cnt_r;
  logic [15:0] frame_cyc_r;
  logic        ratio_stable_r;
  logic [8:0]  gap_r;
  logic        sclk_ovr_r;
  logic [3:0]  rate_code_nxt;

  // Classify a frame length with a window of one part in 32
  function automatic logic [3:0] classify(input logic [15:0] n);
    logic [3:0] code;
    code = RATE_ERR;
    if (in_win(n, F16_CYC)) code = RATE_16K;
    if (in_win(n, F32_CYC)) code = RATE_32K;
    if (in_win(n, F48_CYC)) code = RATE_48K;
    if (in_win(n, F96_CYC)) code = RATE_96K;
    if (in_win(n, F192_CYC)) code = RATE_192K;
    return code;
  endfunction
  function automatic logic in_win(input logic [15:0] n, input int c);
    logic [16:0] lo;
    logic [16:0] hi;
    lo = 17'(c - (c >> TOL_SHIFT));
    hi = 17'(c + (c >> TOL_SHIFT));
    return ({1'b0, n} >= lo) && ({1'b0, n} <= hi);
  endfunction
  assign rate_code_nxt = classify(frame_cyc_r);

  // Count bit clocks and system clocks per frame, saturating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bclk_cnt_r  <= 10'h000;
      frame_cyc_r <= 16'h0000;
    end else if (frame_start) begin
      bclk_cnt_r  <= {9'h000, sclk_rise};
      frame_cyc_r <= 16'h0001;
    end else begin
      if (sclk_rise && bclk_cnt_r != 10'h3FF) bclk_cnt_r <= bclk_cnt_r + 10'h001;
      if (frame_cyc_r != 16'hFFFF) frame_cyc_r <= frame_cyc_r + 16'h0001;
    end
  end

  // Publish ratio and rate once per frame; stability needs two equal frames
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ratio_r        <= 10'h000;
      rate_code_r    <= RATE_ERR;
      ratio_stable_r <= 1'b0;
    end else if (frame_start) begin
      ratio_r        <= bclk_cnt_r;
      rate_code_r    <= rate_code_nxt;
      ratio_stable_r <= (bclk_cnt_r == ratio_r);
    end
  end

  // Gap since last bit clock edge: drives missing and overrate checks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_r      <= 9'h000;
      sclk_ovr_r <= 1'b0;
    end else if (sclk_rise) begin
      gap_r      <= 9'h000;
      sclk_ovr_r <= (32'(gap_r) + 1) < SCLK_MIN_CYC;
    end else if (32'(gap_r) < SCLK_MISS_CYC) begin
      gap_r <= gap_r + 9'h001;
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  logic missing;
  logic rate_bad;
  logic ratio_ok;
  assign missing  = (32'(gap_r) >= SCLK_MISS_CYC);
  assign ratio_ok = (32'(ratio_r) >= RATIO_MIN) && (32'(ratio_r) <= RATIO_MAX);
  // Ignore setting plays no part here; it only affects the audio mute
  assign rate_bad = (rate_mode == 3'h0) ? (rate_code_r == RATE_ERR)
                                        : (cfg_rate_code != rate_code_r);

  // Flags are live levels, refreshed every cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_r <= 6'h00;
    end else begin
      flags_r[FLG_RATE]     <= rate_bad | missing;
      flags_r[FLG_SCLK_OK]  <= ratio_stable_r & ratio_ok & ~missing;
      flags_r[FLG_MISSING]  <= missing;
      flags_r[FLG_PLL_LOCK] <= sync_q2[IX_PEN] & sync_q2[IX_PLK];
      flags_r[FLG_PLL_OVR]  <= sync_q2[IX_POV];
      flags_r[FLG_SCLK_OVR] <= sclk_ovr_r & ~missing;
    end
  end

  // ****************************************
  // Output routing
  // ****************************************
  logic mute_all;
  // Rate errors silence audio unless software chose to ignore them
  assign mute_all = flags_r[FLG_RATE] & ~rate_error_ignore;

  function automatic logic [SAMPLE_W-1:0] route(input apr_src_type s,
      input logic [SAMPLE_W-1:0] own, input logic [SAMPLE_W-1:0] other);
    logic [SAMPLE_W-1:0] v;
    v = '0;
    unique case (s)
      SRC_OWN:   v = own;
      SRC_OTHER: v = other;
      SRC_MUTE:  v = '0;
      SRC_RSVD:  v = '0; // Reserved code plays silence
    endcase
    return v;
  endfunction

  // One routed pair per received pair
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left_out_r  <= '0;
      right_out_r <= '0;
      out_valid_r <= 1'b0;
    end else begin
      out_valid_r <= smp.strobe;
      if (smp.strobe) begin
        left_out_r  <= mute_all ? '0 : route(lsrc, smp.left, smp.right);
        right_out_r <= mute_all ? '0 : route(rsrc, smp.right, smp.left);
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_take_pair;
    smp.strobe && !mute_all;
  endsequence
  sequence s_read_rate;
    reg_rd_en && reg_addr == ADDR_RATE;
  endsequence
  a_left_own_route: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_pair and (lsrc == SRC_OWN) |=> out_valid_r && left_out_r == $past(smp.left))
    else $error("left output not fed from left input");
  a_left_mute_zero: assert property (@(posedge clk) disable iff (!rst_n)
    smp.strobe && lsrc == SRC_MUTE |=> out_valid_r && left_out_r == '0)
    else $error("muted left output not zero");
  a_right_swap_route: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_pair and (rsrc == SRC_OTHER) |=> right_out_r == $past(smp.left))
    else $error("right output not fed from left input");
  a_rsvd_code_silent: assert property (@(posedge clk) disable iff (!rst_n)
    smp.strobe && rsrc == SRC_RSVD |=> right_out_r == '0)
    else $error("reserved selector code not silent");
  a_ratio_high_read: assert property (@(posedge clk) disable iff (!rst_n)
    s_read_rate |=> reg_rdata_r[RATIO_HI_LSB +: 2] == $past(ratio_r[9:8]))
    else $error("ratio high bits misreported");
  a_sclk_ok_range: assert property (@(posedge clk) disable iff (!rst_n)
    flags_r[FLG_SCLK_OK] |-> $past(ratio_r) >= 10'(RATIO_MIN) && $past(ratio_r) <= 10'(RATIO_MAX))
    else $error("bit clock valid with ratio out of range");
  a_fixed_rate_err: assert property (@(posedge clk) disable iff (!rst_n)
    rate_mode != 3'h0 && cfg_rate_code != rate_code_r |=> flags_r[FLG_RATE])
    else $error("fixed rate mismatch not flagged");
  a_missing_after_gap: assert property (@(posedge clk) disable iff (!rst_n)
    !sclk_rise [*8] ##1 (32'(gap_r) == SCLK_MISS_CYC) |=> flags_r[FLG_MISSING])
    else $error("missing bit clock not flagged");
  a_pll_off_unlock: assert property (@(posedge clk) disable iff (!rst_n)
    !sync_q2[IX_PEN] |=> !flags_r[FLG_PLL_LOCK])
    else $error("disabled pll reported locked");
endmodule
`default_nettype wire

// >>> testbench/apr_audio_src.sv
// Model of the external audio source: bit clock, frame clock and data.
// Assumes the bench sets run, half period and slot length between frames.
`timescale 1ns/1ps
`default_nettype none
module apr_audio_src (
  output logic              sclk,
  output logic              lrclk,
  output logic              sdin,
  input  wire logic         run,
  input  var real           half_ns,
  input  var int            slot_bits,
  input  wire logic [23:0]  left_word,
  input  wire logic [23:0]  right_word
);
  int n;
  // One process owns the pins: idle levels first, then one frame per pass.
  // The clock stands still outside frames; lines change while sclk is low, MSB first
  initial begin
    sclk  = 1'b0;
    lrclk = 1'b1;
    sdin  = 1'b0;
    forever begin
      wait (run);
      n = slot_bits;
      for (int ch = 0; ch < 2; ch++) begin
        for (int b = n - 1; b >= 0; b--) begin
          lrclk = ch[0];
          sdin  = (b < 24) ? (ch[0] ? right_word[b] : left_word[b]) : 1'b0;
          #(half_ns) sclk = 1'b1;
          #(half_ns) sclk = 1'b0;
        end
      end
      // Released data line shows no stale bit
      if (!run) sdin = ~sdin;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/apr_route_mon_tb.sv
// Self-checking bench for the routing and clock monitor block.
// Assumes the audio source model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
module apr_route_mon_tb;
  import apr_pkg::*;
  localparam int CEIL = 95000;
  localparam logic [23:0] LW = 24'hABCDE1;
  localparam logic [23:0] RW = 24'h13579B;
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0;
  logic sclk, lrclk, sdin;
  logic pll_enable = 1'b0, pll_locked = 1'b0, pll_overrate = 1'b0;
  logic [2:0] rate_mode = 3'h0;
  logic [3:0] cfg_rate_code = 4'h0;
  logic rate_error_ignore = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_r, rd;
  logic [23:0] left_out_r, right_out_r;
  logic out_valid_r;
  real half_ns = 62.5;
  int slot_bits = 32, errors = 0, checks_done = 0, cyc = 0;

  always #2.5 clk = ~clk;

  apr_audio_src src (.sclk(sclk), .lrclk(lrclk), .sdin(sdin), .run(run), .half_ns(half_ns),
    .slot_bits(slot_bits), .left_word(LW), .right_word(RW));

  // Frame lengths shrunk so one 64-bit frame at 125 ns bits reads as 48 kHz
  apr_route_mon #(.F16_CYC(4800), .F32_CYC(3200), .F48_CYC(1600), .F96_CYC(800), .F192_CYC(400)) dut (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .lrclk(lrclk), .sdin(sdin), .pll_enable(pll_enable),
    .pll_locked(pll_locked), .pll_overrate(pll_overrate), .rate_mode(rate_mode),
    .cfg_rate_code(cfg_rate_code), .rate_error_ignore(rate_error_ignore), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata_r(reg_rdata_r),
    .left_out_r(left_out_r), .right_out_r(right_out_r), .out_valid_r(out_valid_r));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge clk) #1;
    reg_wr_en = 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge clk) #1;
    reg_rd_en = 1'b0;
    rd = reg_rdata_r;
    if (what != "") check(what, rd, exp);
  endtask

  // Unbounded wait for n output pairs, one per frame; only the cycle ceiling ends a hang
  task automatic frames(input int n);
    for (int i = 0; i < n; i++) begin
      // Look just after the edge, while the one-cycle pulse stands
      do begin
        @(posedge clk);
        #1;
      end while (out_valid_r !== 1'b1);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rdc(ADDR_ROUTE, ROUTE_RST, "route");
    check("rsrc", rd[1:0], 2'h1);
    rdc(ADDR_RATE, 8'h00, "rate");
    rdc(ADDR_RATIO, 8'h00, "ratio_lo");
    // Flags are live: no rate seen yet gives bit 0, a disabled PLL reads unlocked
    rdc(ADDR_FLAGS, 8'h01, "flags");
    rdc(8'h36, 8'h00, "unmapped");
  endtask

  task automatic t_mon48();
    frames(4);
    rdc(ADDR_RATE, {4'h0, RATE_48K}, "rate48");
    rdc(ADDR_RATIO, 8'h40, "ratio64");
    rdc(ADDR_FLAGS, 8'h0A, "flags48");
    wr(ADDR_RATIO, 8'hFF);
    rdc(ADDR_RATIO, 8'h40, "ratio_ro");
    wr(ADDR_RATE, 8'hFF);
    rdc(ADDR_RATE, 8'hC9, "rate_ro");
    wr(ADDR_RATE, 8'h00);
  endtask

  task automatic t_route();
    logic [23:0] el, er;
    for (int i = 0; i < 3; i++) begin
      // Left selector sits in bits 5-4, right selector in bits 1-0
      wr(ADDR_ROUTE, {2'h0, i[1:0], 4'h0} | {6'h00, 2'(2 - i)});
      frames(2);
      el = (i == 0) ? 24'h000000 : (i == 1) ? LW : RW;
      er = (i == 2) ? 24'h000000 : (i == 1) ? RW : LW;
      check("left_out", left_out_r, el);
      check("right_out", right_out_r, er);
    end
    wr(ADDR_ROUTE, ROUTE_RST);
  endtask

  task automatic t_fixed();
    rate_mode = 3'h1;
    cfg_rate_code = RATE_96K;
    repeat (6) @(posedge clk);
    rdc(ADDR_FLAGS, 8'h0B, "fixed_err");
    rate_error_ignore = 1'b1;
    repeat (6) @(posedge clk);
    rdc(ADDR_FLAGS, 8'h0B, "ignore_err");
    cfg_rate_code = RATE_48K;
    repeat (6) @(posedge clk);
    rdc(ADDR_FLAGS, 8'h0A, "fixed_ok");
    rate_mode = 3'h0;
    rate_error_ignore = 1'b0;
  endtask

  task automatic t_ratio(input int bits, input logic [7:0] er, input logic [7:0] el,
                         input logic [7:0] ef);
    slot_bits = bits;
    frames(4);
    rdc(ADDR_RATE, er, "rate_hi");
    rdc(ADDR_RATIO, el, "ratio_lo");
    rdc(ADDR_FLAGS, ef, "flags_ratio");
  endtask

  task automatic t_pll();
    pll_overrate = 1'b1;
    repeat (6) @(posedge clk);
    rdc(ADDR_FLAGS, 8'h00, "");
    check("pll_ovr", rd[FLG_PLL_OVR], 1'b1);
    pll_overrate = 1'b0;
    pll_enable = 1'b0;
    repeat (6) @(posedge clk);
    rdc(ADDR_FLAGS, 8'h00, "");
    check("pll_off", rd[FLG_PLL_LOCK], 1'b0);
    pll_enable = 1'b1;
  endtask

  task automatic t_fast_missing();
    half_ns = 10.0;
    frames(2);
    rdc(ADDR_FLAGS, 8'h00, "");
    check("sclk_ovr", rd[FLG_SCLK_OVR], 1'b1);
    run = 1'b0;
    // The source ends its 512-bit frame (about 2048 cycles) before the clock stops
    repeat (2600) @(posedge clk);
    rdc(ADDR_FLAGS, 8'h00, "");
    check("missing", rd[FLG_MISSING], 1'b1);
    check("miss_rate", rd[FLG_RATE], 1'b1);
  endtask

  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == CEIL) begin
      errors++;
      summarize();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset();
    pll_enable = 1'b1;
    pll_locked = 1'b1;
    run = 1'b1;
    t_mon48();
    t_route();
    t_fixed();
    t_ratio(16, {4'h0, RATE_96K}, 8'h20, 8'h0A);
    // Ratio 16 is stable but below 32, so the bit clock is not valid
    t_ratio(8, {4'h0, RATE_192K}, 8'h10, 8'h08);
    t_ratio(256, 8'h20, 8'h00, 8'h0B);
    t_pll();
    t_fast_missing();
    summarize();
  end
endmodule
`default_nettype wire
